// File: stm_pkg.sv
package stm_pkg;
  // register offsets, byte addresses on the wishbone side
  localparam logic [7:0] STM_ADR_CTRL    = 8'h00; // enables, modes, compare valids
  localparam logic [7:0] STM_ADR_STAT    = 8'h04; // interrupt levels, write one to clear
  localparam logic [7:0] STM_ADR_LOAD    = 8'h10; // start values, timer i at +4*i
  localparam logic [7:0] STM_ADR_CNT     = 8'h30; // live counts, timer i at +4*i
  localparam logic [7:0] STM_ADR_CMP     = 8'h50; // up-counter compares, k at +4*k
  localparam logic [7:0] STM_ADR_WD_LOAD = 8'h60; // guard start value, write reloads
  localparam logic [7:0] STM_ADR_WD_CMP  = 8'h64; // guard warning value
  localparam logic [7:0] STM_ADR_WD_CNT  = 8'h68; // guard live count

  // control field positions
  localparam int STM_EN_LSB   = 0;  // six enables: timers 0..4, guard at 5
  localparam int STM_CONT_LSB = 8;  // five continuous-mode bits
  localparam int STM_CMPV_LSB = 16; // four compare-valid bits

  localparam int STM_N_TMR = 5;  // general purpose timers
  localparam int STM_N_CMP = 4;  // compare slots of the up counter
  localparam int STM_WD    = 5;  // guard position in enable and status

  typedef struct packed {
    logic [5:0]                    en;     // run enables
    logic [STM_N_TMR-1:0]          cont;   // continuous mode
    logic [STM_N_CMP-1:0]          cmpv;   // compare slot valid
    logic [STM_N_TMR-1:0][31:0]    load;   // start values
    logic [STM_N_TMR-1:0][31:0]    cnt;    // counts
    logic [STM_N_CMP-1:0][31:0]    cmp;    // compare values
    logic [31:0]                   wd_load;
    logic [31:0]                   wd_cmp;
    logic [31:0]                   wd_cnt;
    logic [5:0]                    stat;   // interrupt levels
    logic                          wd_rst; // system reset request
    logic                          ack;    // wishbone ack
    logic [31:0]                   rdat;   // wishbone read data
  } stm_state_s;

  // value of all state after reset
  localparam stm_state_s STM_ST_RST = '0;
endpackage

// File: stm_tick_sync.sv
`timescale 1ns/1ns
// turns the free-running 1 MHz oscillator into a one-cycle core tick
module stm_tick_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_osc_1mhz,
  output logic      o_tick
);
  typedef struct packed {
    logic s1;   // first sync stage, read only by s2
    logic s2;   // second sync stage
    logic s3;   // delayed copy for edge detection
    logic tick; // registered tick pulse
  } stm_sync_s;

  stm_sync_s st_ff;
  stm_sync_s nxt_st;

  // edge detect looks only at the second stage and later
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = i_osc_1mhz;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.tick = st_ff.s2 & ~st_ff.s3;
  end

  // synchronous active-low reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_tick = st_ff.tick;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  property p_tick_once;
    o_tick |=> !o_tick;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("tick longer than one cycle");
endmodule

// File: stm_timers.sv
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module stm_timers (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_osc_1mhz,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_bus_down_counter_a_irq,
  output logic             o_bus_down_counter_b_irq,
  output logic             o_compare_up_counter_irq,
  output logic             o_slow_down_counter_a_irq,
  output logic             o_slow_down_counter_b_irq,
  output logic             o_lockup_guard_counter_irq,
  output logic             o_lockup_guard_counter_rst
);
  stm_pkg::stm_state_s st_ff;  // all block state
  stm_pkg::stm_state_s nxt_st; // its next value
  logic                tick;   // 1 MHz tick, one core cycle
  logic                wr;     // write takes effect this edge
  logic [5:0]          set;    // interrupt events this cycle
  logic [5:0]          clr;    // software clears this cycle
  logic [31:0]         rd_val; // read mux
  logic [31:0]         up_nxt; // up counter after step
  logic [31:0]         wd_nxt; // guard count after step
  logic [3:0]          hit;    // per-slot compare hits

  // tick from the oscillator, synchronised inside
  stm_tick_sync u_tick (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_osc_1mhz (i_osc_1mhz),
    .o_tick     (tick)
  );

  // bank decode: address in base .. base+4*(n-1), word aligned
  function automatic logic in_bank(input logic [7:0] adr, input logic [7:0] base,
                                   input logic [2:0] n, output logic [2:0] idx);
    logic [7:0] off;
    off = adr - base;
    idx = off[4:2];
    in_bank = (adr >= base) && (off[1:0] == 2'b00) && (off[7:2] < {3'b000, n});
  endfunction

  // byte-lane merge under wishbone select
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // compare hits of the up counter, one per slot
  for (genvar k = 0; k < stm_pkg::STM_N_CMP; k++) begin : g_hit
    assign hit[k] = st_ff.cmpv[k] && (up_nxt == st_ff.cmp[k]);
  end
  assign up_nxt = st_ff.cnt[2] + 32'h1;
  assign wd_nxt = st_ff.wd_cnt - 32'h1;

  // read mux, unmapped words read as zero
  always_comb begin
    logic [2:0] idx;
    idx    = 3'd0;
    rd_val = 32'h0000_0000;
    if (i_wb_adr == stm_pkg::STM_ADR_CTRL) begin
      rd_val[stm_pkg::STM_EN_LSB +: 6]   = st_ff.en;
      rd_val[stm_pkg::STM_CONT_LSB +: 5] = st_ff.cont;
      rd_val[stm_pkg::STM_CMPV_LSB +: 4] = st_ff.cmpv;
    end else if (i_wb_adr == stm_pkg::STM_ADR_STAT) begin
      rd_val[5:0] = st_ff.stat;
    end else if (in_bank(i_wb_adr, stm_pkg::STM_ADR_LOAD, 3'd5, idx)) begin
      rd_val = st_ff.load[idx];
    end else if (in_bank(i_wb_adr, stm_pkg::STM_ADR_CNT, 3'd5, idx)) begin
      rd_val = st_ff.cnt[idx];
    end else if (in_bank(i_wb_adr, stm_pkg::STM_ADR_CMP, 3'd4, idx)) begin
      rd_val = st_ff.cmp[idx[1:0]];
    end else if (i_wb_adr == stm_pkg::STM_ADR_WD_LOAD) begin
      rd_val = st_ff.wd_load;
    end else if (i_wb_adr == stm_pkg::STM_ADR_WD_CMP) begin
      rd_val = st_ff.wd_cmp;
    end else if (i_wb_adr == stm_pkg::STM_ADR_WD_CNT) begin
      rd_val = st_ff.wd_cnt;
    end
  end

  // next state: counting first, then software writes override
  always_comb begin
    logic [2:0]  idx;
    logic [31:0] wv;
    logic        step;
    idx    = 3'd0;
    wv     = 32'h0000_0000;
    step   = 1'b0;
    nxt_st = st_ff;
    set    = 6'b000000;
    clr    = 6'b000000;
    // write lands on the edge where the master sees ack
    wr = i_wb_cyc && i_wb_stb && i_wb_we && st_ff.ack;

    // down counters 0,1,3,4
    for (int i = 0; i < stm_pkg::STM_N_TMR; i++) begin
      if (i != 2) begin
        // bus timers step every clock, whatever its rate; slow ones on tick
        step = (i < 2) ? 1'b1 : tick;
        if (st_ff.en[i] && step) begin
          if (st_ff.cnt[i] <= 32'h1) begin
            set[i] = 1'b1;
            if (st_ff.cont[i]) begin
              nxt_st.cnt[i] = st_ff.load[i];
            end else begin
              nxt_st.cnt[i] = 32'h0;
              nxt_st.en[i]  = 1'b0;
            end
          end else begin
            nxt_st.cnt[i] = st_ff.cnt[i] - 32'h1;
          end
        end
      end
    end

    // up counter with compare slots
    if (st_ff.en[2] && tick) begin
      nxt_st.cnt[2] = up_nxt;
      if (|hit) begin
        set[2] = 1'b1;
        if (!st_ff.cont[2]) begin
          nxt_st.en[2] = 1'b0;
        end
      end
    end

    // lockup guard: warning at compare, system reset at zero
    if (st_ff.en[stm_pkg::STM_WD] && tick) begin
      if (st_ff.wd_cnt <= 32'h1) begin
        nxt_st.wd_cnt                = 32'h0;
        nxt_st.wd_rst                = 1'b1;
        nxt_st.en[stm_pkg::STM_WD]   = 1'b0;
      end else begin
        nxt_st.wd_cnt = wd_nxt;
        if (wd_nxt == st_ff.wd_cmp) begin
          set[stm_pkg::STM_WD] = 1'b1;
        end
      end
    end

    // software writes
    if (wr) begin
      if (i_wb_adr == stm_pkg::STM_ADR_CTRL) begin
        wv = merge({12'h000, st_ff.cmpv, 3'b000, st_ff.cont, 2'b00, st_ff.en},
                   i_wb_dat, i_wb_sel);
        nxt_st.en   = wv[stm_pkg::STM_EN_LSB +: 6];
        nxt_st.cont = wv[stm_pkg::STM_CONT_LSB +: 5];
        nxt_st.cmpv = wv[stm_pkg::STM_CMPV_LSB +: 4];
      end else if (i_wb_adr == stm_pkg::STM_ADR_STAT) begin
        clr = i_wb_sel[0] ? i_wb_dat[5:0] : 6'b000000;
      end else if (in_bank(i_wb_adr, stm_pkg::STM_ADR_LOAD, 3'd5, idx)) begin
        // start value also seeds the count; on the up counter it presets it
        wv                  = merge(st_ff.load[idx], i_wb_dat, i_wb_sel);
        nxt_st.load[idx]    = wv;
        nxt_st.cnt[idx]     = wv;
      end else if (in_bank(i_wb_adr, stm_pkg::STM_ADR_CMP, 3'd4, idx)) begin
        nxt_st.cmp[idx[1:0]] = merge(st_ff.cmp[idx[1:0]], i_wb_dat, i_wb_sel);
      end else if (i_wb_adr == stm_pkg::STM_ADR_WD_LOAD) begin
        // rewriting the start value is the periodic service
        wv             = merge(st_ff.wd_load, i_wb_dat, i_wb_sel);
        nxt_st.wd_load = wv;
        nxt_st.wd_cnt  = wv;
      end else if (i_wb_adr == stm_pkg::STM_ADR_WD_CMP) begin
        nxt_st.wd_cmp = merge(st_ff.wd_cmp, i_wb_dat, i_wb_sel);
      end
    end

    // levels hold until cleared; a new event beats a same-cycle clear
    nxt_st.stat = (st_ff.stat & ~clr) | set;

    // single-cycle ack, read data latched with it
    nxt_st.ack  = i_wb_cyc && i_wb_stb && !st_ff.ack;
    nxt_st.rdat = (i_wb_cyc && i_wb_stb && !st_ff.ack && !i_wb_we) ? rd_val : st_ff.rdat;
  end

  // state register, synchronous active-low reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_ff <= stm_pkg::STM_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output straight from the state register
  assign o_wb_dat                   = st_ff.rdat;
  assign o_wb_ack                   = st_ff.ack;
  assign o_bus_down_counter_a_irq   = st_ff.stat[0];
  assign o_bus_down_counter_b_irq   = st_ff.stat[1];
  assign o_compare_up_counter_irq   = st_ff.stat[2];
  assign o_slow_down_counter_a_irq  = st_ff.stat[3];
  assign o_slow_down_counter_b_irq  = st_ff.stat[4];
  assign o_lockup_guard_counter_irq = st_ff.stat[5];
  assign o_lockup_guard_counter_rst = st_ff.wd_rst;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  property p_bus_dec;
    st_ff.en[0] && st_ff.cnt[0] > 32'h1 && !wr |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) - 32'h1;
  endproperty
  a_bus_dec: assert property (p_bus_dec) else $error("bus timer missed a decrement");

  property p_load;
    wr && i_wb_adr == stm_pkg::STM_ADR_LOAD + 8'h0C && i_wb_sel == 4'hF
      |=> st_ff.cnt[3] == $past(i_wb_dat) && st_ff.load[3] == $past(i_wb_dat);
  endproperty
  a_load: assert property (p_load) else $error("start value not taken");

  property p_single;
    st_ff.en[0] && !st_ff.cont[0] && st_ff.cnt[0] == 32'h1 && !wr
      |=> !st_ff.en[0] && st_ff.cnt[0] == 32'h0 && o_bus_down_counter_a_irq;
  endproperty
  a_single: assert property (p_single) else $error("single shot did not stop");

  property p_cont;
    st_ff.en[1] && st_ff.cont[1] && st_ff.cnt[1] == 32'h1 && !wr
      |=> st_ff.en[1] && st_ff.cnt[1] == $past(st_ff.load[1]);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous timer did not reload");

  property p_zero_irq;
    st_ff.en[0] && st_ff.cnt[0] <= 32'h1 |=> o_bus_down_counter_a_irq;
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("no interrupt at zero");

  property p_slow;
    st_ff.en[3] && !tick && !wr |=> $stable(st_ff.cnt[3]);
  endproperty
  a_slow: assert property (p_slow) else $error("slow timer moved without tick");

  property p_match;
    st_ff.en[2] && tick && |hit && !st_ff.cont[2] && !wr
      |=> o_compare_up_counter_irq && !st_ff.en[2];
  endproperty
  a_match: assert property (p_match) else $error("up counter match mishandled");

  property p_wd_dec;
    st_ff.en[5] && tick && st_ff.wd_cnt > 32'h1 && !wr
      |=> st_ff.wd_cnt == $past(st_ff.wd_cnt) - 32'h1;
  endproperty
  a_wd_dec: assert property (p_wd_dec) else $error("guard missed a decrement");

  property p_wd_rst;
    st_ff.en[5] && tick && st_ff.wd_cnt <= 32'h1 |=> o_lockup_guard_counter_rst [*2];
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("guard did not reset system");

  property p_wd_warn;
    st_ff.en[5] && tick && st_ff.wd_cnt > 32'h1 && wd_nxt == st_ff.wd_cmp
      |=> o_lockup_guard_counter_irq;
  endproperty
  a_wd_warn: assert property (p_wd_warn) else $error("guard warning missing");

  property p_level;
    o_slow_down_counter_a_irq && !clr[3] |=> o_slow_down_counter_a_irq;
  endproperty
  a_level: assert property (p_level) else $error("interrupt dropped without clear");

  property p_ack;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("wishbone ack timing wrong");

  // up counter advances by one on every tick, match or not
  property p_up_step;
    st_ff.en[2] && tick && !wr |=> st_ff.cnt[2] == $past(st_ff.cnt[2]) + 32'h1;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up counter missed a step");

  // reset request only leaves through the block reset
  property p_wd_stick;
    o_lockup_guard_counter_rst |=> o_lockup_guard_counter_rst;
  endproperty
  a_wd_stick: assert property (p_wd_stick) else $error("guard reset request dropped");

  c_zero:  cover property (st_ff.en[0] && st_ff.cnt[0] == 32'h1 ##1 o_bus_down_counter_a_irq);
  c_match: cover property (st_ff.en[2] && tick && |hit);
  c_warn:  cover property (!o_lockup_guard_counter_irq ##1 o_lockup_guard_counter_irq);
  c_rst:   cover property (!o_lockup_guard_counter_rst ##1 o_lockup_guard_counter_rst);
endmodule

// File: stm_timers_tb.sv
`timescale 1ns/1ns
// one compare: counts it, reports a mismatch at once
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: got %0h exp %0h", $time, (got), (exp)); end end

module stm_timers_tb;
  logic        clk;             // core clock, 100 MHz
  logic        rst_b;           // synchronous reset, active low
  logic        osc;             // 1 MHz oscillator, phase unrelated to clk
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  irq;             // timers 0..4, guard at 5
  logic        wd_rst;          // system reset request
  wire  [6:0]  ev = {wd_rst, irq};
  int          error_cnt;
  int          samples_checked;
  int          cycles;          // timeout counter
  logic [31:0] rv;
  int          n;

  stm_timers i_stm_timers (
    .i_core_clk                 (clk),
    .i_rst_b                    (rst_b),
    .i_osc_1mhz                 (osc),
    .i_wb_cyc                   (cyc),
    .i_wb_stb                   (stb),
    .i_wb_we                    (we),
    .i_wb_adr                   (adr),
    .i_wb_sel                   (sel),
    .i_wb_dat                   (wdat),
    .o_wb_dat                   (rdat),
    .o_wb_ack                   (ack),
    .o_bus_down_counter_a_irq   (irq[0]),
    .o_bus_down_counter_b_irq   (irq[1]),
    .o_compare_up_counter_irq   (irq[2]),
    .o_slow_down_counter_a_irq  (irq[3]),
    .o_slow_down_counter_b_irq  (irq[4]),
    .o_lockup_guard_counter_irq (irq[5]),
    .o_lockup_guard_counter_rst (wd_rst)
  );

  // clocks: core and a free oscillator with an odd start offset
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #137;
    forever #500 osc = ~osc;
  end

  // verdict and end of run, the only exit
  task automatic end_sim();
    $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, generous for the slowest guard scenario
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end

  // classic wishbone cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    // no wait-state count assumed; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    `CHK(ack, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF, rv);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF, rv);
    `CHK(rv, e)
  endtask
  // bounded wait on one event line, n gives the cycles spent
  // looks from the next edge on: a clear written just before is still
  // landing in this time step and must not end the wait at once
  task automatic wait_ev(input int i, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ev[i] !== 1'b1 && n < lim);
  endtask

  // reset values, unmapped place
  task automatic t_reset();
    `CHK(ev, 7'h00)
    rdc(stm_pkg::STM_ADR_CTRL, 32'h0);
    rdc(stm_pkg::STM_ADR_CNT, 32'h0);
    wr(8'hF0, 32'hFFFFFFFF);
    rdc(8'hF0, 32'h0);
    // byte lanes: only lane 1 of the warning value may change
    xfer(1'b1, stm_pkg::STM_ADR_WD_CMP, 32'hA5A5_A5A5, 4'h2, rv);
    rdc(stm_pkg::STM_ADR_WD_CMP, 32'h0000_A500);
  endtask

  // bus timer a, single shot: rate, stop, level irq, clear
  task automatic t_bus_single();
    wr(stm_pkg::STM_ADR_LOAD, 32'h8);
    wr(stm_pkg::STM_ADR_CTRL, 32'h1);
    wait_ev(0, 100);
    `CHK(irq[0], 1'b1)
    `CHK(n >= 6 && n <= 10, 1'b1)
    repeat (20) @(posedge clk);
    `CHK(irq[0], 1'b1)
    rdc(stm_pkg::STM_ADR_CNT, 32'h0);
    rdc(stm_pkg::STM_ADR_CTRL, 32'h0);
    wr(stm_pkg::STM_ADR_STAT, 32'h1);
    rdc(stm_pkg::STM_ADR_STAT, 32'h0);
    `CHK(irq[0], 1'b0)
  endtask

  // bus timer b, continuous: reloads and fires again
  task automatic t_bus_cont();
    wr(stm_pkg::STM_ADR_LOAD + 8'h04, 32'h10);
    wr(stm_pkg::STM_ADR_CTRL, 32'h202);
    wait_ev(1, 100);
    `CHK(irq[1], 1'b1)
    wr(stm_pkg::STM_ADR_STAT, 32'h2);
    wait_ev(1, 100);
    `CHK(irq[1], 1'b1)
    `CHK(n >= 8, 1'b1)
    rdc(stm_pkg::STM_ADR_CTRL, 32'h202);
    wr(stm_pkg::STM_ADR_CTRL, 32'h0);
    wr(stm_pkg::STM_ADR_STAT, 32'h2);
  endtask

  // slow timers step on the tick, not the core clock
  task automatic t_slow();
    wr(stm_pkg::STM_ADR_LOAD + 8'h0C, 32'h3);
    wr(stm_pkg::STM_ADR_LOAD + 8'h10, 32'h2);
    wr(stm_pkg::STM_ADR_CTRL, 32'h18);
    repeat (50) @(posedge clk);
    `CHK(irq[4:3], 2'b00)
    wait_ev(4, 400);
    `CHK(irq[4], 1'b1)
    wait_ev(3, 400);
    `CHK(irq[3], 1'b1)
    rdc(stm_pkg::STM_ADR_CTRL, 32'h0);
    wr(stm_pkg::STM_ADR_STAT, 32'h18);
  endtask

  // up counter: every compare slot one-shot, then continuous
  task automatic t_compare();
    for (int k = 0; k < stm_pkg::STM_N_CMP; k++) begin
      wr(stm_pkg::STM_ADR_LOAD + 8'h08, 32'h0);
      wr(stm_pkg::STM_ADR_CMP + 8'(4 * k), 32'(2 + k));
      wr(stm_pkg::STM_ADR_CTRL, 32'h4 | (32'h1 << (16 + k)));
      wait_ev(2, 1000);
      `CHK(irq[2], 1'b1)
      `CHK(n >= 90 * (k + 1), 1'b1)
      rdc(stm_pkg::STM_ADR_CNT + 8'h08, 32'(2 + k));
      rdc(stm_pkg::STM_ADR_CTRL, 32'h1 << (16 + k));
      wr(stm_pkg::STM_ADR_STAT, 32'h4);
    end
    wr(stm_pkg::STM_ADR_LOAD + 8'h08, 32'h0);
    wr(stm_pkg::STM_ADR_CMP, 32'h2);
    wr(stm_pkg::STM_ADR_CTRL, 32'h10404);
    wait_ev(2, 1000);
    `CHK(irq[2], 1'b1)
    wr(stm_pkg::STM_ADR_STAT, 32'h4);
    repeat (300) @(posedge clk);
    xfer(1'b0, stm_pkg::STM_ADR_CNT + 8'h08, 32'h0, 4'hF, rv);
    `CHK(rv > 32'h2, 1'b1)
    rdc(stm_pkg::STM_ADR_CTRL, 32'h10404);
    wr(stm_pkg::STM_ADR_CTRL, 32'h0);
    wr(stm_pkg::STM_ADR_STAT, 32'h4);
  endtask

  // guard: warning, service, then the sticky system reset
  task automatic t_guard();
    wr(stm_pkg::STM_ADR_WD_CMP, 32'h3);
    wr(stm_pkg::STM_ADR_WD_LOAD, 32'h6);
    wr(stm_pkg::STM_ADR_CTRL, 32'h20);
    wait_ev(5, 600);
    `CHK(irq[5], 1'b1)
    `CHK(wd_rst, 1'b0)
    wr(stm_pkg::STM_ADR_WD_LOAD, 32'h6);
    xfer(1'b0, stm_pkg::STM_ADR_WD_CNT, 32'h0, 4'hF, rv);
    `CHK(rv >= 32'h5, 1'b1)
    wr(stm_pkg::STM_ADR_STAT, 32'h20);
    wait_ev(6, 1000);
    `CHK(wd_rst, 1'b1)
    `CHK(n >= 300, 1'b1)
    repeat (50) @(posedge clk);
    `CHK(wd_rst, 1'b1)
    rdc(stm_pkg::STM_ADR_WD_CNT, 32'h0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK(wd_rst, 1'b0)
    `CHK(ev, 7'h00)
  endtask

  // main sequence, inputs defined at time zero
  initial begin
    rst_b           = 1'b0;
    cyc             = 1'b0;
    stb             = 1'b0;
    we              = 1'b0;
    adr             = 8'h00;
    sel             = 4'hF;
    wdat            = 32'h0;
    error_cnt       = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_bus_single();
    t_bus_cont();
    t_slow();
    t_compare();
    t_guard();
    end_sim();
  end
endmodule
